// *** pkg/rcs_pkg.sv ***
// constants for the clock status, interrupt and compensation block
`default_nettype none
package rcs_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_TIME       = 8'h00;
  localparam logic [7:0] OFF_ALARM      = 8'h20;
  localparam logic [7:0] OFF_CTRL       = 8'h40;
  localparam logic [7:0] OFF_STATUS     = 8'h44;
  localparam logic [7:0] OFF_INT_CTRL   = 8'h48;
  localparam logic [7:0] OFF_COMP_LOW   = 8'h4c;
  localparam logic [7:0] OFF_COMP_HIGH  = 8'h50;
  localparam logic [7:0] OFF_OSC        = 8'h54;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h58;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h5c;
  // ==========================================================
  // field positions
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_MODE12_BIT  = 3;
  localparam int ST_RESET_BIT     = 7;
  localparam int ST_ALARM_BIT     = 6;
  localparam int INT_ALARM_EN_BIT = 3;
  localparam int INT_TIMER_EN_BIT = 2;
  localparam int OSC_PWRDN_BIT    = 4;
  localparam int TIME_SEC_LSB     = 0;
  localparam int TIME_MIN_LSB     = 8;
  localparam int TIME_HOUR_LSB    = 16;
  localparam int TIME_PM_BIT      = 23;
  localparam int IRQ_ALARM_BIT    = 0;
  localparam int IRQ_TIMER_BIT    = 1;
  // ==========================================================
  // reset values
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  INT_CTRL_RESET = 8'h00;
  localparam logic [7:0]  COMP_RESET     = 8'h00;
  localparam logic [4:0]  OSC_RESET      = 5'h00;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;
  localparam logic [20:0] ALARM_RESET    = 21'h000000;
  // ==========================================================
  // counts and timing
  localparam logic [15:0] CNT_LAST       = 16'h7fff;
  localparam logic [5:0]  SEC_LAST       = 6'h3b;
  localparam logic [5:0]  MIN_LAST       = 6'h3b;
  localparam logic [4:0]  HOUR_LAST      = 5'h17;
  localparam logic [4:0]  HOUR_NOON      = 5'h0c;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          TIMER_PULSE_NS = 15000;
  localparam int          TIMER_PULSE_CYC =
    (TIMER_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage
`default_nettype wire

// *** rtl/rcs_top.sv ***
// status, interrupt, drift compensation and oscillator control block
`default_nettype none
module rcs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        tick_32k,
  input  wire logic        osc_test_mux_select,
  input  wire logic        test_osc_powerdown,
  input  wire logic [3:0]  test_osc_trim,
  output logic             alarm_irq_n,
  output logic             timer_irq_n,
  output logic             irq,
  output logic             osc_powerdown_ctrl,
  output logic [3:0]       osc_resistance_trim
);

  // ==========================================================
  // declarations
  logic [7:0]  aw_addr;
  logic        aw_full;
  logic [31:0] w_data;
  logic        w_full;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  ctrl;
  logic [7:0]  int_ctrl;
  logic [7:0]  comp_low;
  logic [7:0]  comp_high;
  logic [4:0]  osc_reg;
  logic [20:0] alarm_time;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        reset_flag;
  logic        alarm_flag;
  logic        day_elapsed_flag;
  logic        hour_elapsed_flag;
  logic        minute_elapsed_flag;
  logic        second_elapsed_flag;
  logic        run_s1;
  logic        run_s2;
  logic [15:0] cnt32;
  logic [5:0]  sec;
  logic [5:0]  min;
  logic [4:0]  hour;
  logic        tick_run;
  logic        sec_roll;
  logic        min_roll;
  logic        hour_roll;
  logic        day_roll;
  logic        busy;
  logic        alarm_match;
  logic        alarm_match_d;
  logic        alarm_event;
  logic        period_event;
  logic        timer_event;
  logic [7:0]  timer_cnt;
  logic [15:0] comp_value;
  logic [31:0] time_view;
  logic [31:0] next_rdata;
  logic        next_rerr;
  logic        wr_status;
  logic        wr_time;
  logic [4:0]  wr_hour;
  logic        mode12;
  logic        alarm_irq_enable;
  logic        periodic_irq_enable;
  logic [3:0]  wstrb_q;
  // noon in the 24-hour count, shared by both format helpers
  localparam logic [4:0] HOUR_NOON_C = rcs_pkg::HOUR_NOON;

  // ==========================================================
  // hour format helpers
  // 24-hour value to displayed hour (1..12 in 12-hour format)
  function automatic logic [4:0] hour_out(input logic [4:0] h,
                                          input logic m12);
    logic [4:0] r;
    r = h;
    if (m12)
    begin
      if (h == 5'h00)
        r = HOUR_NOON_C;
      else if (h > HOUR_NOON_C)
        r = h - HOUR_NOON_C;
    end
    return r;
  endfunction

  // displayed hour and pm flag back to the 24-hour count
  function automatic logic [4:0] hour_in(input logic [4:0] h,
                                         input logic pm,
                                         input logic m12);
    logic [4:0] r;
    r = h;
    if (m12)
    begin
      r = (h == HOUR_NOON_C) ? 5'h00 : h;
      if (pm)
        r = r + HOUR_NOON_C;
    end
    return r;
  endfunction

  assign mode12              = ctrl[rcs_pkg::CTRL_MODE12_BIT];
  assign alarm_irq_enable    = int_ctrl[rcs_pkg::INT_ALARM_EN_BIT];
  assign periodic_irq_enable = int_ctrl[rcs_pkg::INT_TIMER_EN_BIT];
  assign comp_value          = {comp_high, comp_low};

  // ==========================================================
  // axi4-lite write channel
  // address and data are caught in either order; one write at a time
  assign wr_go = aw_full & w_full & ~bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      awready <= 1'b0;
    end
    else if (awvalid && awready)
    begin
      aw_full <= 1'b1;
      aw_addr <= awaddr;
      awready <= 1'b0;
    end
    else
    begin
      if (wr_go)
        aw_full <= 1'b0;
      if (!aw_full && !bvalid)
        awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      wready <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      w_full <= 1'b1;
      w_data <= wdata;
      wready <= 1'b0;
    end
    else
    begin
      if (wr_go)
        w_full <= 1'b0;
      if (!w_full && !bvalid)
        wready <= 1'b1;
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= rcs_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      case (aw_addr)
        rcs_pkg::OFF_TIME, rcs_pkg::OFF_ALARM, rcs_pkg::OFF_CTRL,
        rcs_pkg::OFF_STATUS, rcs_pkg::OFF_INT_CTRL,
        rcs_pkg::OFF_COMP_LOW, rcs_pkg::OFF_COMP_HIGH,
        rcs_pkg::OFF_OSC, rcs_pkg::OFF_IRQ_STATUS,
        rcs_pkg::OFF_IRQ_MASK: bresp <= rcs_pkg::RESP_OKAY;
        default:               bresp <= rcs_pkg::RESP_SLVERR;
      endcase
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ==========================================================
  // plain control registers; byte lane 0 must be enabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl       <= rcs_pkg::CTRL_RESET;
      int_ctrl   <= rcs_pkg::INT_CTRL_RESET;
      comp_low   <= rcs_pkg::COMP_RESET;
      comp_high  <= rcs_pkg::COMP_RESET;
      osc_reg    <= rcs_pkg::OSC_RESET;
      alarm_time <= rcs_pkg::ALARM_RESET;
      irq_mask   <= rcs_pkg::IRQ_RESET;
    end
    else if (wr_go && w_strb_ok(w_data, aw_addr))
    begin
      case (aw_addr)
        rcs_pkg::OFF_CTRL:      ctrl      <= w_data[7:0];
        rcs_pkg::OFF_INT_CTRL:  int_ctrl  <= {4'h0, w_data[3:0]};
        rcs_pkg::OFF_COMP_LOW:  comp_low  <= w_data[7:0];
        rcs_pkg::OFF_COMP_HIGH: comp_high <= w_data[7:0];
        rcs_pkg::OFF_OSC:       osc_reg   <= w_data[4:0];
        rcs_pkg::OFF_ALARM:     alarm_time <= w_data[20:0];
        rcs_pkg::OFF_IRQ_MASK:  irq_mask  <= w_data[1:0];
        default:                ctrl      <= ctrl;
      endcase
    end
  end

  // strobe lane 0 gate, kept as a function so the address is unused
  function automatic logic w_strb_ok(input logic [31:0] d,
                                     input logic [7:0] a);
    logic ok;
    ok = wstrb_q[0];
    return ok;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wstrb_q <= 4'h0;
    else if (wvalid && wready)
      wstrb_q <= wstrb;
  end

  assign wr_status = wr_go & wstrb_q[0] & (aw_addr == rcs_pkg::OFF_STATUS);
  assign wr_time   = wr_go & wstrb_q[0] & (aw_addr == rcs_pkg::OFF_TIME);
  assign wr_hour   = hour_in(w_data[rcs_pkg::TIME_HOUR_LSB +: 5],
                             w_data[rcs_pkg::TIME_PM_BIT], mode12);

  // ==========================================================
  // run request crossing: two stages clocked by the 32 kHz tick
  // so the running state follows the request only after a delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
    end
    else if (tick_32k)
    begin
      run_s1 <= ctrl[rcs_pkg::CTRL_RUN_BIT];
      run_s2 <= run_s1;
    end
  end

  // ==========================================================
  // 32 kHz counter and time of day
  assign tick_run  = tick_32k & run_s2;
  assign sec_roll  = tick_run & (cnt32 == rcs_pkg::CNT_LAST);
  assign min_roll  = sec_roll & (sec == rcs_pkg::SEC_LAST);
  assign hour_roll = min_roll & (min == rcs_pkg::MIN_LAST);
  assign day_roll  = hour_roll & (hour == rcs_pkg::HOUR_LAST);
  // last tick before a rollover is about 30 us, covering the 15 us window
  assign busy      = run_s2 & (cnt32 == rcs_pkg::CNT_LAST);

  // the hourly restart point is minus the compensation, so ffff makes
  // the counter start one ahead and 0001 one behind
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt32 <= 16'h0000;
    else if (hour_roll)
      cnt32 <= 16'h0000 - comp_value;
    else if (sec_roll)
      cnt32 <= 16'h0000;
    else if (tick_run)
      cnt32 <= cnt32 + 16'h0001;
  end

  // a host time write wins over a simultaneous increment
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec  <= 6'h00;
      min  <= 6'h00;
      hour <= 5'h00;
    end
    else if (wr_time)
    begin
      sec  <= w_data[rcs_pkg::TIME_SEC_LSB +: 6];
      min  <= w_data[rcs_pkg::TIME_MIN_LSB +: 6];
      hour <= wr_hour;
    end
    else if (sec_roll)
    begin
      sec <= min_roll ? 6'h00 : sec + 6'h01;
      if (min_roll)
        min <= hour_roll ? 6'h00 : min + 6'h01;
      if (hour_roll)
        hour <= day_roll ? 5'h00 : hour + 5'h01;
    end
  end

  // ==========================================================
  // elapsed flags: set by their event, cleared by a status read;
  // a set in the reading cycle wins
  assign rd_go = arvalid & arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      day_elapsed_flag    <= 1'b0;
      hour_elapsed_flag   <= 1'b0;
      minute_elapsed_flag <= 1'b0;
      second_elapsed_flag <= 1'b0;
    end
    else
    begin
      if (rd_go && araddr == rcs_pkg::OFF_STATUS)
      begin
        day_elapsed_flag    <= 1'b0;
        hour_elapsed_flag   <= 1'b0;
        minute_elapsed_flag <= 1'b0;
        second_elapsed_flag <= 1'b0;
      end
      if (day_roll)
        day_elapsed_flag <= 1'b1;
      if (hour_roll)
        hour_elapsed_flag <= 1'b1;
      if (min_roll)
        minute_elapsed_flag <= 1'b1;
      if (sec_roll)
        second_elapsed_flag <= 1'b1;
    end
  end

  // ==========================================================
  // alarm: one event on the edge where time reaches the alarm value
  assign alarm_match = ({hour, 2'h0, min, 2'h0, sec} == alarm_time);
  assign alarm_event = alarm_irq_enable & alarm_match & ~alarm_match_d;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alarm_match_d <= 1'b1;
    else
      alarm_match_d <= alarm_match;
  end

  // sticky flags; writing one clears, a new event wins; only bits 7
  // and 6 are writable, the rest ignore host data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reset_flag <= 1'b1;
      alarm_flag <= 1'b0;
    end
    else
    begin
      if (wr_status && w_data[rcs_pkg::ST_RESET_BIT])
        reset_flag <= 1'b0;
      if (alarm_event)
        alarm_flag <= 1'b1;
      else if (wr_status && w_data[rcs_pkg::ST_ALARM_BIT])
        alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alarm_irq_n <= 1'b1;
    else
      alarm_irq_n <= ~(alarm_flag | alarm_event);
  end

  // ==========================================================
  // periodic timer pulse
  always_comb
  begin
    case (int_ctrl[1:0])
      2'h0:    period_event = sec_roll;
      2'h1:    period_event = min_roll;
      2'h2:    period_event = hour_roll;
      2'h3:    period_event = day_roll;
      default: period_event = 1'b0;
    endcase
  end

  assign timer_event = periodic_irq_enable & period_event;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_cnt   <= 8'h00;
      timer_irq_n <= 1'b1;
    end
    else if (timer_event)
    begin
      timer_cnt   <= 8'(rcs_pkg::TIMER_PULSE_CYC - 1);
      timer_irq_n <= 1'b0;
    end
    else if (timer_cnt != 8'h00)
      timer_cnt <= timer_cnt - 8'h01;
    else
      timer_irq_n <= 1'b1;
  end

  // ==========================================================
  // summary interrupt: sticky causes, write one clears, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= rcs_pkg::IRQ_RESET;
    else
    begin
      if (wr_go && wstrb_q[0] && aw_addr == rcs_pkg::OFF_IRQ_STATUS)
        irq_status <= irq_status & ~w_data[1:0];
      if (alarm_event)
        irq_status[rcs_pkg::IRQ_ALARM_BIT] <= 1'b1;
      if (timer_event)
        irq_status[rcs_pkg::IRQ_TIMER_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // ==========================================================
  // oscillator control, test path takes over when selected
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_powerdown_ctrl  <= 1'b0;
      osc_resistance_trim <= 4'h0;
    end
    else if (!osc_test_mux_select)
    begin
      osc_powerdown_ctrl  <= osc_reg[rcs_pkg::OSC_PWRDN_BIT];
      osc_resistance_trim <= osc_reg[3:0];
    end
    else
    begin
      osc_powerdown_ctrl  <= test_osc_powerdown;
      osc_resistance_trim <= test_osc_trim;
    end
  end

  // ==========================================================
  // read channel
  always_comb
  begin
    time_view = 32'h00000000;
    time_view[rcs_pkg::TIME_SEC_LSB +: 6]  = sec;
    time_view[rcs_pkg::TIME_MIN_LSB +: 6]  = min;
    time_view[rcs_pkg::TIME_HOUR_LSB +: 5] = hour_out(hour, mode12);
    time_view[rcs_pkg::TIME_PM_BIT] = mode12 & (hour >= HOUR_NOON_C);
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    case (araddr)
      rcs_pkg::OFF_TIME:       next_rdata = time_view;
      rcs_pkg::OFF_ALARM:      next_rdata = {11'h000, alarm_time};
      rcs_pkg::OFF_CTRL:       next_rdata = {24'h000000, ctrl};
      rcs_pkg::OFF_STATUS:
        next_rdata = {24'h000000, reset_flag, alarm_flag,
                      day_elapsed_flag, hour_elapsed_flag,
                      minute_elapsed_flag, second_elapsed_flag,
                      run_s2, busy};
      rcs_pkg::OFF_INT_CTRL:   next_rdata = {24'h000000, int_ctrl};
      rcs_pkg::OFF_COMP_LOW:   next_rdata = {24'h000000, comp_low};
      rcs_pkg::OFF_COMP_HIGH:  next_rdata = {24'h000000, comp_high};
      rcs_pkg::OFF_OSC:        next_rdata = {27'h0000000, osc_reg};
      rcs_pkg::OFF_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
      rcs_pkg::OFF_IRQ_MASK:   next_rdata = {30'h00000000, irq_mask};
      default:                 next_rerr  = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= rcs_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= next_rerr ? rcs_pkg::RESP_SLVERR : rcs_pkg::RESP_OKAY;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
    else if (!rvalid)
      arready <= 1'b1;
  end

endmodule
`default_nettype wire

// *** verif/rcs_monitor.sv ***
// assertion checker for the status, interrupt and oscillator block
`default_nettype none
module rcs_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        timer_irq_n,
  input wire logic        alarm_irq_n,
  input wire logic        osc_test_mux_select,
  input wire logic        test_osc_powerdown,
  input wire logic [3:0]  test_osc_trim,
  input wire logic        osc_powerdown_ctrl,
  input wire logic [3:0]  osc_resistance_trim
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // helper: low cycles of the current timer pulse
  localparam int PULSE = rcs_pkg::TIMER_PULSE_CYC;
  int low_cnt;
  // counted here since a 150-long repetition would choke the tools
  always_ff @(posedge aclk)
    low_cnt <= (!aresetn || timer_irq_n) ? 0 : low_cnt + 1;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // bus handshake sequences
  sequence s_b_done;
    bvalid && bready;
  endsequence
  sequence s_reopen;
    !awready ##1 awready;
  endsequence
  chk_aw_refuse: assert property (awvalid && awready |=> !awready)
    else $error("address slot stayed open after a transfer");
  chk_b_reopen: assert property (s_b_done |=> s_reopen)
    else $error("address slot did not reopen after the response");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed while waiting");
  chk_r_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped or changed while waiting");
  chk_timer_width: assert property ($rose(timer_irq_n) |-> low_cnt == PULSE)
    else $error("timer pulse has the wrong length");
  chk_alarm_release: assert property ($rose(alarm_irq_n) |->
    $past(bvalid) || $past(bvalid, 2) || $past(bvalid, 3))
    else $error("alarm output released without a host write");
  chk_osc_test: assert property (osc_test_mux_select |=>
    osc_powerdown_ctrl == $past(test_osc_powerdown) &&
    osc_resistance_trim == $past(test_osc_trim))
    else $error("oscillator not fed from the test inputs");
endmodule
bind rcs_top rcs_monitor rcs_monitor_i (.*);
`default_nettype wire

// *** verif/rcs_osc_model.sv ***
// tick source standing in for the 32 kHz oscillator
`default_nettype none
module rcs_osc_model (
  input  wire logic aclk,
  input  wire logic ticking,
  output logic      tick_32k
);
  timeunit 1ns;
  timeprecision 1ns;
  // a tick every cycle: one second is 32768 cycles, keeps the run short
  always_ff @(posedge aclk)
    tick_32k <= ticking;
endmodule
`default_nettype wire

// *** verif/rcs_top_tb.sv ***
// self-checking testbench for the status and interrupt block
`default_nettype none
module rcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ticking;
  logic        tick_32k, osc_test_mux_select, test_osc_powerdown;
  logic        alarm_irq_n, timer_irq_n, irq, osc_powerdown_ctrl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, test_osc_trim, osc_resistance_trim;
  logic [1:0]  bresp, rresp;
  int          miscompares, cmp_count;
  rcs_top rcs_top_i (.*);
  rcs_osc_model rcs_osc_model_i (.*);
  // ==========================================================
  // clock, watchdog and shared tasks
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial
  begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    final_report;
  end
  task automatic final_report;
    $display("checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
    end
    while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    while (arvalid || rready);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check("register", d, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(8'h44, 32'h80);
    rd_chk(8'h4c, 32'h0);
    rd_chk(8'h50, 32'h0);
    rd_chk(8'h48, 32'h0);
    rd(8'h60, d, r);
    check("unmapped resp", 32'(r), 32'(rcs_pkg::RESP_SLVERR));
    $display("test reset done");
  endtask
  task automatic t_status;
    wr(8'h44, 32'h3f);
    rd_chk(8'h44, 32'h80);
    wr(8'h44, 32'h80);
    rd_chk(8'h44, 32'h0);
    $display("test status done");
  endtask
  task automatic t_regs;
    // all ones means one period dropped per hour; count 0000 is skipped
    wr(8'h4c, 32'hff);
    wr(8'h50, 32'hff);
    rd_chk(8'h4c, 32'hff);
    rd_chk(8'h50, 32'hff);
    wr(8'h54, 32'h1a);
    rd_chk(8'h54, 32'h1a);
    check("powerdown", 32'(osc_powerdown_ctrl), 32'h1);
    check("trim", 32'(osc_resistance_trim), 32'ha);
    osc_test_mux_select <= 1'b1;
    test_osc_trim <= 4'h5;
    repeat (3) @(posedge aclk);
    check("test trim", 32'(osc_resistance_trim), 32'h5);
    check("test pd", 32'(osc_powerdown_ctrl), 32'h0);
    osc_test_mux_select <= 1'b0;
    repeat (3) @(posedge aclk);
    check("trim back", 32'(osc_resistance_trim), 32'ha);
    // 1 pm written in 12-hour form, read back in both forms
    wr(8'h40, 32'h8);
    wr(8'h00, 32'h00810000);
    rd_chk(8'h00, 32'h00810000);
    wr(8'h40, 32'h0);
    rd_chk(8'h00, 32'h000d0000);
    $display("test registers done");
  endtask
  task automatic t_second;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h48, 32'hc);
    wr(8'h5c, 32'h3);
    wr(8'h40, 32'h1);
    ticking <= 1'b1;
    n = 0;
    while (timer_irq_n === 1'b1 && n < 40000)
    begin
      @(posedge aclk);
      n++;
    end
    check("timer pin", 32'(timer_irq_n), 32'h0);
    repeat (4) @(posedge aclk);
    ticking <= 1'b0; // later writes land with the counter held
    check("alarm pin", 32'(alarm_irq_n), 32'h0);
    check("irq", 32'(irq), 32'h1);
    rd(8'h44, d, r);
    check("status", d & 32'hfe, 32'h46);
    rd(8'h44, d, r);
    check("status reread", d & 32'hfe, 32'h42);
    wr(8'h44, 32'h40);
    repeat (3) @(posedge aclk);
    check("alarm cleared", 32'(alarm_irq_n), 32'h1);
    wr(8'h58, 32'h3);
    repeat (3) @(posedge aclk);
    check("irq cleared", 32'(irq), 32'h0);
    repeat (200) @(posedge aclk);
    check("timer released", 32'(timer_irq_n), 32'h1);
    $display("test second done");
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ticking} = '0;
    {osc_test_mux_select, test_osc_powerdown, test_osc_trim} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_status;
    t_regs;
    t_second;
    final_report;
  end
endmodule
`default_nettype wire
